/* File: core/sgr_read_core.sv */
`timescale 1ns/1ps
`default_nettype none
module sgr_read_core (
  input wire logic clk,
  input wire logic rstn,
  input wire logic write_data_clock,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [3:0] cmd_bank,
  input wire logic [11:0] cmd_addr,
  input wire logic [7:0] cmd_addr_fall,
  input wire logic [4:0] programmed_read_latency_cycles,
  input wire logic mode_x16,
  input wire logic mode_mirror,
  input wire logic on_die_termination_en,
  input wire logic read_inversion_en,
  input wire logic [31:0] wr_dq,
  input wire logic wr_dq_valid,
  output logic [31:0] dq_o,
  output logic dq_oe,
  output logic [3:0] bus_inversion_flag_o,
  output logic bus_inversion_flag_oe,
  output logic on_die_termination_on,
  output logic precharge_pulse,
  output logic [3:0] precharge_bank,
  output logic wr_commit,
  output logic [31:0] wr_byte_en
);
  localparam int DW = sgr_pkg::DATA_W;
  localparam int NB = sgr_pkg::BYTES;
  localparam int BT = sgr_pkg::BEATS;
  localparam int BURST_W = DW * BT;

  function automatic logic [7:0] lane_mask(input logic [15:0] r, input logic [7:0] f,
                                           input logic hi);
    if (hi) begin
      lane_mask = {f[7:4], r[sgr_pkg::P_H3], r[sgr_pkg::P_H2], r[sgr_pkg::P_H1],
                   r[sgr_pkg::P_H0]};
    end else begin
      lane_mask = {f[3:0], r[sgr_pkg::P_L3], r[sgr_pkg::P_L2], r[sgr_pkg::P_L1],
                   r[sgr_pkg::P_L0]};
    end
  endfunction

  // Inverting a byte with more than four zeros keeps at most four lanes driven low.
  function automatic logic inv_byte(input logic [7:0] b);
    int z;
    z = 0;
    for (int i = 0; i < 8; i++) begin
      z += int'(!b[i]);
    end
    inv_byte = z > 4;
  endfunction

  logic [DW-1:0] mem [BT * (2 ** sgr_pkg::COL_W)];
  sgr_pkg::sgr_ws_type ws_state_reg, ws_state_next;

  // Command decode.
  logic bus_free;
  logic rd_cmd;
  logic act_cmd;
  logic mw_cmd;
  logic [sgr_pkg::LAT_W-1:0] lat;
  logic [15:0] rise_bits;
  logic [7:0] m_lo;
  logic [7:0] m_hi;
  assign bus_free = ws_state_reg != sgr_pkg::WS_MASK1 && ws_state_reg != sgr_pkg::WS_MASK2;
  assign rd_cmd = cmd_valid && bus_free && cmd_op == sgr_pkg::OP_READ;
  assign act_cmd = cmd_valid && bus_free && cmd_op == sgr_pkg::OP_ACT;
  assign mw_cmd = cmd_valid && bus_free && cmd_op == sgr_pkg::OP_MASKED_WR;
  assign lat = programmed_read_latency_cycles;
  assign rise_bits = {cmd_bank, cmd_addr};
  assign m_lo = lane_mask(rise_bits, cmd_addr_fall, 1'b0);
  assign m_hi = lane_mask(rise_bits, cmd_addr_fall, 1'b1);

  // Start line: a one travels down to bit zero and starts the burst on time.
  logic [sgr_pkg::LINE_W-1:0] line_reg;
  logic [sgr_pkg::LINE_W-1:0] line_next;
  logic burst_start;
  assign line_next = {1'b0, line_reg[sgr_pkg::LINE_W-1:1]} |
                     (rd_cmd ? (32'h0000_0001 << (lat - 5'h1)) : '0); // RULE_05
  assign burst_start = line_reg[0];

  // Fetch engine runs ahead of the pins and is held back by the FIFO.
  logic pend_valid_reg;
  logic [sgr_pkg::COL_W-1:0] pend_col_reg;
  logic fetch_busy_reg;
  logic [sgr_pkg::COL_W-1:0] fetch_col_reg;
  logic [sgr_pkg::BEAT_W-1:0] fetch_beat_reg;
  logic f_in_ready;
  logic f_out_valid;
  logic [DW-1:0] f_out_data;
  logic push_ok;
  logic fetch_done;
  logic fetch_load;
  logic pop;
  assign push_ok = fetch_busy_reg && f_in_ready;
  assign fetch_done = push_ok && fetch_beat_reg == 3'h7; // RULE_01
  assign fetch_load = pend_valid_reg && (!fetch_busy_reg || fetch_done);

  sgr_fifo #(.W(DW), .DEPTH(sgr_pkg::FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(fetch_busy_reg),
    .in_ready(f_in_ready),
    .in_data(mem[{fetch_col_reg, fetch_beat_reg}]),
    .out_valid(f_out_valid),
    .out_ready(pop),
    .out_data(f_out_data)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_valid_reg <= 1'b0;
      pend_col_reg <= '0;
      fetch_busy_reg <= 1'b0;
      fetch_col_reg <= '0;
      fetch_beat_reg <= '0;
    end else begin
      if (rd_cmd) begin
        pend_valid_reg <= 1'b1; // RULE_10
        pend_col_reg <= cmd_addr[sgr_pkg::COL_W-1:0]; // RULE_01
      end else if (fetch_load) begin
        pend_valid_reg <= 1'b0;
      end
      if (fetch_load) begin
        fetch_busy_reg <= 1'b1;
        fetch_col_reg <= pend_col_reg;
        fetch_beat_reg <= '0;
      end else if (fetch_done) begin
        fetch_busy_reg <= 1'b0;
      end else if (push_ok) begin
        fetch_beat_reg <= fetch_beat_reg + 3'h1;
      end
    end
  end

  // Output stage: a new start adds eight beats to what is still owed, so
  // nothing already started is dropped and back-to-back bursts run on.
  logic [4:0] out_cnt_reg;
  logic [4:0] out_cnt_next;
  logic beat_reg;
  logic [NB-1:0] inv;
  logic [DW-1:0] rd_word;
  assign pop = burst_start || out_cnt_reg != '0; // RULE_04 RULE_09
  assign out_cnt_next = out_cnt_reg - 5'(pop) + (burst_start ? 5'(BT) : 5'h00); // RULE_01

  for (genvar y = 0; y < NB; y++) begin : g_inv
    assign inv[y] = read_inversion_en && inv_byte(f_out_data[8*y +: 8]);
    assign rd_word[8*y +: 8] = inv[y] ? ~f_out_data[8*y +: 8] : f_out_data[8*y +: 8];
  end

  logic [DW-1:0] dq_reg;
  logic dq_oe_reg;
  logic [NB-1:0] flag_reg;
  logic term_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      line_reg <= '0;
      out_cnt_reg <= sgr_pkg::OUT_CNT_RST;
      beat_reg <= 1'b0;
      dq_reg <= '1;
      dq_oe_reg <= 1'b0;
      flag_reg <= '1;
      term_reg <= 1'b0;
    end else begin
      line_reg <= line_next;
      out_cnt_reg <= out_cnt_next;
      beat_reg <= pop;
      dq_reg <= pop ? rd_word : '1; // RULE_06
      flag_reg <= pop ? ~inv : '1; // RULE_16
      dq_oe_reg <= pop || (beat_reg && on_die_termination_en); // RULE_06 RULE_08
      term_reg <= !pop && !beat_reg && on_die_termination_en; // RULE_07
    end
  end

  // Bank timing and auto precharge.
  logic [sgr_pkg::CNT_W-1:0] ras_cnt_reg [sgr_pkg::NBANK];
  logic [sgr_pkg::CNT_W-1:0] wait_cnt_reg [sgr_pkg::NBANK];
  logic [sgr_pkg::NBANK-1:0] ap_reg;
  logic [sgr_pkg::NBANK-1:0] pc_ready;
  logic pc_any;
  logic [3:0] pc_sel;
  logic pc_reg;
  logic [3:0] pc_bank_reg;
  for (genvar i = 0; i < sgr_pkg::NBANK; i++) begin : g_rdy
    assign pc_ready[i] = ap_reg[i] && ras_cnt_reg[i] == '0 && wait_cnt_reg[i] == '0; // RULE_03
  end
  always_comb begin
    pc_any = 1'b0;
    pc_sel = '0;
    for (int i = sgr_pkg::NBANK - 1; i >= 0; i--) begin
      if (pc_ready[i]) begin
        pc_any = 1'b1;
        pc_sel = 4'(i);
      end
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < sgr_pkg::NBANK; i++) begin
        ras_cnt_reg[i] <= sgr_pkg::CNT_RST;
        wait_cnt_reg[i] <= sgr_pkg::CNT_RST;
      end
      ap_reg <= '0;
      pc_reg <= 1'b0;
      pc_bank_reg <= '0;
    end else begin
      for (int i = 0; i < sgr_pkg::NBANK; i++) begin
        if (act_cmd && cmd_bank == 4'(i)) ras_cnt_reg[i] <= 6'(sgr_pkg::RAS_CYC); // RULE_03
        else if (ras_cnt_reg[i] != '0) ras_cnt_reg[i] <= ras_cnt_reg[i] - 6'h01;
        if (rd_cmd && cmd_bank == 4'(i) && cmd_addr[sgr_pkg::AP_BIT]) begin // RULE_02
          ap_reg[i] <= 1'b1;
          wait_cnt_reg[i] <= 6'(lat) + 6'(BT);
        end else begin
          if (wait_cnt_reg[i] != '0) wait_cnt_reg[i] <= wait_cnt_reg[i] - 6'h01;
          if (pc_any && pc_sel == 4'(i)) ap_reg[i] <= 1'b0;
        end
      end
      pc_reg <= pc_any;
      pc_bank_reg <= pc_sel;
    end
  end

  // Write data arrives on its own clock; a full burst is parked and flagged by toggle.
  logic [BURST_W-1:0] asm_reg;
  logic [BURST_W-1:0] hold_reg;
  logic [sgr_pkg::BEAT_W-1:0] wbeat_reg;
  logic tgl_reg;
  always_ff @(posedge write_data_clock or negedge rstn) begin
    if (!rstn) begin
      asm_reg <= '0;
      hold_reg <= '0;
      wbeat_reg <= '0;
      tgl_reg <= 1'b0;
    end else if (wr_dq_valid) begin
      asm_reg[32*wbeat_reg +: 32] <= wr_dq;
      wbeat_reg <= wbeat_reg + 3'h1;
      if (wbeat_reg == 3'h7) begin
        hold_reg <= {wr_dq, asm_reg[BURST_W-DW-1:0]};
        tgl_reg <= ~tgl_reg;
      end
    end
  end

  logic tgl_s1_reg;
  logic tgl_s2_reg;
  logic tgl_s3_reg;
  logic data_ev;
  logic data_rdy_reg;
  logic commit;
  assign data_ev = tgl_s2_reg ^ tgl_s3_reg;
  assign commit = ws_state_reg == sgr_pkg::WS_WAIT && data_rdy_reg;

  // Masked write sequence: address cycle, then two mask cycles.
  logic [sgr_pkg::COL_W-1:0] ws_col_reg;
  logic [7:0] msk_reg [NB];
  logic [DW-1:0] byte_en;
  logic wr_commit_reg;
  logic [DW-1:0] wr_byte_en_reg;
  for (genvar b = 0; b < BT; b++) begin : g_be_b
    for (genvar y = 0; y < NB; y++) begin : g_be_y
      assign byte_en[b*NB + y] = msk_reg[y][b] != sgr_pkg::MASK_ON; // RULE_17
    end
  end
  always_comb begin
    ws_state_next = ws_state_reg;
    unique case (ws_state_reg)
      sgr_pkg::WS_IDLE: if (mw_cmd) ws_state_next = sgr_pkg::WS_MASK1; // RULE_15
      sgr_pkg::WS_MASK1: ws_state_next = sgr_pkg::WS_MASK2;
      sgr_pkg::WS_MASK2: ws_state_next = sgr_pkg::WS_WAIT;
      sgr_pkg::WS_WAIT: if (data_rdy_reg) ws_state_next = sgr_pkg::WS_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ws_state_reg <= sgr_pkg::WS_IDLE;
      ws_col_reg <= '0;
      for (int y = 0; y < NB; y++) msk_reg[y] <= {8{sgr_pkg::MASK_ON}};
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
      tgl_s3_reg <= 1'b0;
      data_rdy_reg <= 1'b0;
      wr_commit_reg <= 1'b0;
      wr_byte_en_reg <= '0;
    end else begin
      ws_state_reg <= ws_state_next;
      if (mw_cmd && ws_state_reg == sgr_pkg::WS_IDLE) ws_col_reg <= cmd_addr[sgr_pkg::COL_W-1:0];
      if (ws_state_reg == sgr_pkg::WS_MASK1) begin
        msk_reg[0] <= (mode_x16 && mode_mirror) ? {8{sgr_pkg::MASK_ON}} : m_lo; // RULE_12 RULE_14
        msk_reg[2] <= (mode_x16 && mode_mirror) ? {8{sgr_pkg::MASK_ON}} : m_hi; // RULE_12 RULE_14
      end
      if (ws_state_reg == sgr_pkg::WS_MASK2) begin
        msk_reg[1] <= (mode_x16 && !mode_mirror) ? {8{sgr_pkg::MASK_ON}} : m_lo; // RULE_12 RULE_13
        msk_reg[3] <= (mode_x16 && !mode_mirror) ? {8{sgr_pkg::MASK_ON}} : m_hi; // RULE_12 RULE_13
      end
      tgl_s1_reg <= tgl_reg;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
      data_rdy_reg <= data_ev || (data_rdy_reg && !commit && !mw_cmd);
      wr_commit_reg <= commit;
      if (commit) wr_byte_en_reg <= byte_en;
    end
  end
  always_ff @(posedge clk) begin
    if (commit) begin
      for (int b = 0; b < BT; b++) begin
        for (int y = 0; y < NB; y++) begin
          if (byte_en[b*NB + y]) mem[{ws_col_reg, 3'(b)}][8*y +: 8] <= hold_reg[DW*b + 8*y +: 8]; // RULE_17
        end
      end
    end
  end

  assign dq_o = dq_reg;
  assign dq_oe = dq_oe_reg;
  assign bus_inversion_flag_o = flag_reg;
  assign bus_inversion_flag_oe = dq_oe_reg;
  assign on_die_termination_on = term_reg;
  assign precharge_pulse = pc_reg;
  assign precharge_bank = pc_bank_reg;
  assign wr_commit = wr_commit_reg;
  assign wr_byte_en = wr_byte_en_reg;

  // Cycles since the last read command, used only by the latency check.
  logic [sgr_pkg::AGE_W-1:0] rd_age_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) rd_age_reg <= '1;
    else if (rd_cmd) rd_age_reg <= '0;
    else if (rd_age_reg != '1) rd_age_reg <= rd_age_reg + 6'h01;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_eight;
    beat_reg [*8];
  endsequence
  sequence s_mask_steps;
    ws_state_reg == sgr_pkg::WS_MASK1 ##1 ws_state_reg == sgr_pkg::WS_MASK2;
  endsequence
  a_burst_eight_beats: assert property (burst_start |=> s_eight) // RULE_01
    else $error("read burst shorter than eight beats");
  a_no_truncation: assert property ($rose(beat_reg) |-> s_eight) // RULE_04
    else $error("read burst was cut short");
  a_read_latency: assert property ($rose(beat_reg) && lat < 5'h08 |-> 6'(lat) == rd_age_reg) // RULE_05
    else $error("first beat not at programmed latency");
  a_idle_ones: assert property ($fell(beat_reg) && $past(on_die_termination_en) |->
                                dq_oe && dq_o == '1 && bus_inversion_flag_o == '1) // RULE_06
    else $error("lanes not driven high after burst");
  a_term_return: assert property ($fell(beat_reg) && $past(on_die_termination_en) &&
                                 on_die_termination_en ##1 !beat_reg |-> on_die_termination_on) // RULE_07
    else $error("termination not back one clock after burst");
  a_hiz_no_odt: assert property ($fell(beat_reg) && !$past(on_die_termination_en) |->
                                 !dq_oe && !bus_inversion_flag_oe) // RULE_08
    else $error("lanes not released with termination off");
  // A start while the last beat of the previous burst is on the pins must not leave a hole.
  a_gapless_reads: assert property (burst_start && beat_reg |=> beat_reg ##1 beat_reg) // RULE_09
    else $error("gap between concatenated bursts");
  a_flag_true_data: assert property (beat_reg && !$past(read_inversion_en) |->
                                     bus_inversion_flag_o == '1) // RULE_16
    else $error("inversion flag low without inversion");
  a_ap_after_ras: assert property (pc_any |-> ras_cnt_reg[pc_sel] == '0 && wait_cnt_reg[pc_sel] == '0
                                   ##1 precharge_pulse && precharge_bank == $past(pc_sel)) // RULE_03
    else $error("precharge before burst end or activate minimum");
  a_mask_write_cycles: assert property (mw_cmd && ws_state_reg == sgr_pkg::WS_IDLE |=> s_mask_steps) // RULE_15
    else $error("masked write did not take mask cycles");
  a_x16_lanes: assert property (wr_commit && $past(mode_x16, 2) && $past(mode_x16, 3) |->
                                (wr_byte_en & ($past(mode_mirror, 2) ? sgr_pkg::EVEN_BYTES
                                 : sgr_pkg::ODD_BYTES)) == '0) // RULE_13 RULE_14
    else $error("absent x16 byte lanes were written");
endmodule
`default_nettype wire

/* File: core/sgr_pkg.sv */
// Functional notes
// RULE_01: Every read returns exactly eight beats.
// RULE_02: Address bit eight selects auto precharge.
// RULE_03: Auto precharge after burst and activate minimum.
// RULE_04: Read bursts are never cut short.
// RULE_05: First beat after programmed read latency.
// RULE_06: Idle after burst drives all ones.
// RULE_07: Termination back within one clock.
// RULE_08: Termination off releases lanes instead.
// RULE_09: Timely next read continues data gaplessly.
// RULE_10: Controller spaces reads by column interval.
// RULE_11: Controller activates bank before reading it.
// RULE_12: Wide mode mask cycles map byte pairs.
// RULE_13: Narrow mode uses first mask cycle only.
// RULE_14: Mirrored narrow uses second cycle only.
// RULE_15: Masked write takes three command cycles.
// RULE_16: Inversion flag high means true data.
// RULE_17: Masked bytes stay unwritten, others written.
package sgr_pkg;
  localparam int DATA_W = 32;
  localparam int BYTES = 4;
  localparam int BEATS = 8;
  localparam int BEAT_W = 3;
  localparam int COL_W = 3;
  localparam int BANK_W = 4;
  localparam int NBANK = 16;
  localparam int ADDR_W = 12;
  localparam int LAT_W = 5;
  localparam int LINE_W = 32;
  localparam int CNT_W = 6;
  localparam int AGE_W = 6;
  localparam int FIFO_DEPTH = 4;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RAS_MIN_NS = 30;
  localparam int RAS_CYC = (RAS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] OP_NOP = 2'h0;
  localparam logic [1:0] OP_ACT = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_MASKED_WR = 2'h3;
  localparam int AP_BIT = 8;
  // Positions inside {bank, address} of the rising-edge mask bits, beats 0 to 3.
  localparam int P_L0 = 10;
  localparam int P_L1 = 9;
  localparam int P_L2 = 12;
  localparam int P_L3 = 15;
  localparam int P_H0 = 14;
  localparam int P_H1 = 13;
  localparam int P_H2 = 11;
  localparam int P_H3 = 8;
  localparam logic MASK_ON = 1'h1;
  localparam logic [31:0] EVEN_BYTES = 32'h5555_5555;
  localparam logic [31:0] ODD_BYTES = 32'hAAAA_AAAA;
  localparam logic [5:0] CNT_RST = 6'h00;
  localparam logic [4:0] OUT_CNT_RST = 5'h00;
  typedef enum logic [1:0] {WS_IDLE, WS_MASK1, WS_MASK2, WS_WAIT} sgr_ws_type;
endpackage

/* File: core/sgr_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module sgr_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;
  assign in_ready = cnt_reg != (AW+1)'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign out_data = mem[rp_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wp_reg <= wp_reg + AW'(1);
      if (pop) rp_reg <= rp_reg + AW'(1);
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge clk) begin
    if (push) mem[wp_reg] <= in_data;
  end
endmodule
`default_nettype wire

/* File: tb/sgr_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sgr_ctrl_model (
  output logic write_data_clock,
  output logic [31:0] wr_dq,
  output logic wr_dq_valid
);
  logic [31:0] beat_q [8];
  initial begin
    write_data_clock = 1'h0;
    wr_dq = 32'h0000_0000;
    wr_dq_valid = 1'h0;
  end
  // The link clock stands still outside a frame, so two idle edges close each frame.
  // The core parks the burst and flips the toggle on the eighth edge; the idle edges change nothing there.
  task automatic send();
    #7;
    for (int i = 0; i < 10; i++) begin
      wr_dq_valid = (i < 8);
      wr_dq = (i < 8) ? beat_q[i] : ~wr_dq;
      #20 write_data_clock = 1'h1;
      #40 write_data_clock = 1'h0;
      #20;
    end
    wr_dq_valid = 1'h0;
  endtask
endmodule
`default_nettype wire

/* File: tb/test_sgram_read_burst_and_byte_mask.sv */
`timescale 1ns/1ps
`default_nettype none
module test_sgram_read_burst_and_byte_mask;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic cmd_valid = 1'h0;
  logic [1:0] cmd_op = sgr_pkg::OP_NOP;
  logic [3:0] cmd_bank = 4'h0;
  logic [11:0] cmd_addr = 12'h000;
  logic [7:0] cmd_addr_fall = 8'h00;
  logic [4:0] cl = 5'h03;
  logic x16 = 1'h0;
  logic mirror = 1'h0;
  logic term_en = 1'h1;
  logic inv_en = 1'h0;
  wire logic wd_clk;
  wire logic wr_dq_valid;
  wire logic [31:0] wr_dq;
  wire logic [31:0] dq_o;
  wire logic dq_oe;
  wire logic [3:0] flag_o;
  wire logic flag_oe;
  wire logic term_on;
  wire logic pre_pulse;
  wire logic [3:0] pre_bank;
  wire logic wr_commit;
  wire logic [31:0] wr_byte_en;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  logic [31:0] mem [64];

  sgr_ctrl_model pm (.write_data_clock(wd_clk), .wr_dq(wr_dq), .wr_dq_valid(wr_dq_valid));
  sgr_read_core dut (.clk(clk), .rstn(rstn), .write_data_clock(wd_clk), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr), .cmd_addr_fall(cmd_addr_fall),
    .programmed_read_latency_cycles(cl), .mode_x16(x16), .mode_mirror(mirror),
    .on_die_termination_en(term_en), .read_inversion_en(inv_en), .wr_dq(wr_dq),
    .wr_dq_valid(wr_dq_valid), .dq_o(dq_o), .dq_oe(dq_oe), .bus_inversion_flag_o(flag_o),
    .bus_inversion_flag_oe(flag_oe), .on_die_termination_on(term_on),
    .precharge_pulse(pre_pulse), .precharge_bank(pre_bank), .wr_commit(wr_commit),
    .wr_byte_en(wr_byte_en));

  always #5 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cmd(input logic [1:0] op, input logic [3:0] ba, input logic [11:0] a,
                     input logic [7:0] f);
    @(negedge clk);
    cmd_valid = 1'h1;
    cmd_op = op;
    cmd_bank = ba;
    cmd_addr = a;
    cmd_addr_fall = f;
  endtask

  task automatic idle();
    @(negedge clk);
    cmd_valid = 1'h0;
    cmd_op = sgr_pkg::OP_NOP;
  endtask

  // Bit beat*4+byte is high when that byte of that beat gets written.
  function automatic logic [31:0] be_of(input logic [3:0] b1, input logic [11:0] a1,
      input logic [7:0] f1, input logic [3:0] b2, input logic [11:0] a2, input logic [7:0] f2);
    logic [7:0] m [4];
    logic [31:0] r;
    m[0] = {f1[3:0], b1[3], b1[0], a1[9], a1[10]};
    m[2] = {f1[7:4], a1[8], a1[11], b1[1], b1[2]};
    m[1] = {f2[3:0], b2[3], b2[0], a2[9], a2[10]};
    m[3] = {f2[7:4], a2[8], a2[11], b2[1], b2[2]};
    for (int t = 0; t < 8; t++)
      for (int b = 0; b < 4; b++)
        r[t*4+b] = ~m[b][t] & (~x16 | (b[0] == mirror));
    return r;
  endfunction

  task automatic mask_write(input logic [2:0] col, input logic [3:0] b1, input logic [11:0] a1,
      input logic [7:0] f1, input logic [3:0] b2, input logic [11:0] a2, input logic [7:0] f2,
      input logic [31:0] base);
    logic [31:0] exp;
    int n;
    exp = be_of(b1, a1, f1, b2, a2, f2);
    cmd(sgr_pkg::OP_MASKED_WR, 4'h0, {9'h000, col}, 8'h00);
    cmd(sgr_pkg::OP_NOP, b1, a1, f1);
    cmd(sgr_pkg::OP_NOP, b2, a2, f2);
    idle();
    for (int i = 0; i < 8; i++)
      pm.beat_q[i] = base + 32'h1111_1111 * i;
    n = 0;
    fork
      pm.send();
      begin
        while (wr_commit !== 1'h1 && n < 200) begin
          @(negedge clk);
          n++;
        end
        chk("wr_commit", wr_commit, 1'h1);
      end
    join
    chk("wr_byte_en", wr_byte_en, exp);
    for (int t = 0; t < 8; t++)
      for (int b = 0; b < 4; b++)
        if (exp[t*4+b])
          mem[col*8+t][b*8+:8] = pm.beat_q[t][b*8+:8];
    // The link frame ends off the command clock; realign so mode changes land on a falling edge.
    @(negedge clk);
  endtask

  task automatic rd(input logic [2:0] c1, input int nb, input logic ap, input logic [3:0] ba);
    logic [31:0] w;
    logic [3:0] fl;
    fork
      for (int i = 0; i < nb; i++) begin
        cmd(sgr_pkg::OP_READ, ba, {3'h0, ap, 5'h00, c1 + 3'(i)}, 8'h00);
        idle();
        repeat (6) @(negedge clk);
      end
      begin
        @(negedge clk);
        @(posedge clk);
        repeat (cl) @(posedge clk);
        for (int j = 0; j < 8 * nb; j++) begin
          @(negedge clk);
          w = mem[(c1 + j / 8) * 8 + j % 8];
          for (int b = 0; b < 4; b++) begin
            fl[b] = !(inv_en && $countones(w[b*8+:8]) < 4);
            if (!fl[b])
              w[b*8+:8] = ~w[b*8+:8];
          end
          chk("dq_o", dq_o, w);
          chk("flag_o", flag_o, fl);
          chk("dq_oe", dq_oe, 1'h1);
          chk("flag_oe", flag_oe, 1'h1);
        end
        @(negedge clk);
        chk("idle_dq", dq_o, 32'hFFFF_FFFF);
        chk("idle_oe", dq_oe, term_en);
        chk("idle_foe", flag_oe, term_en);
        chk("idle_flag", flag_o, 4'hF);
        chk("early_pre", pre_pulse, 1'h0);
        @(negedge clk);
        chk("rel_oe", dq_oe, 1'h0);
        chk("rel_foe", flag_oe, 1'h0);
        chk("term_on", term_on, term_en);
        chk("pre_pulse", pre_pulse, ap);
        if (ap)
          chk("pre_bank", pre_bank, ba);
      end
    join
  endtask

  initial begin
    repeat (10) @(negedge clk);
    chk("rst_oe", dq_oe, 1'h0);
    chk("rst_be", wr_byte_en, 32'h0000_0000);
    repeat (2) @(negedge clk);
    rstn = 1'h1;
    @(negedge clk);
    chk("term_start", term_on, 1'h1);
    mask_write(3'h2, 4'h0, 12'h000, 8'h00, 4'h0, 12'h000, 8'h00, 32'h0100_FF0F);
    mask_write(3'h3, 4'h0, 12'h000, 8'h00, 4'h0, 12'h000, 8'h00, 32'h8040_2010);
    mask_write(3'h5, 4'h0, 12'h000, 8'h00, 4'h0, 12'h000, 8'h00, 32'h00FF_7F3C);
    mask_write(3'h2, 4'h5, 12'hA01, 8'h96, 4'hA, 12'h5FE, 8'h69, 32'h1234_5678);
    x16 = 1'h1;
    mask_write(3'h5, 4'hC, 12'h3C3, 8'h0F, 4'h0, 12'h000, 8'h00, 32'hCAFE_0001);
    mirror = 1'h1;
    // First mask cycle left unmasked: any use of it in this mode would write bytes 0 and 2.
    mask_write(3'h5, 4'h0, 12'h000, 8'h00, 4'h3, 12'h90C, 8'hE1, 32'h0F0F_0000);
    x16 = 1'h0;
    mirror = 1'h0;
    cmd(sgr_pkg::OP_ACT, 4'h1, 12'h000, 8'h00);
    idle();
    repeat (3) @(negedge clk);
    rd(3'h2, 2, 1'h0, 4'h1);
    cl = 5'h07;
    inv_en = 1'h1;
    term_en = 1'h0;
    cmd(sgr_pkg::OP_ACT, 4'h3, 12'h000, 8'h00);
    idle();
    repeat (3) @(negedge clk);
    rd(3'h5, 1, 1'h1, 4'h3);
    end_sim();
  end
endmodule
`default_nettype wire
